// ===== rtl/tcc_channels.sv
// Overview of operation
// - Selected event channel triggers channel A, next ones trigger B, C, D.
// - Capture copies the counter into each enabled channel only.
// - Period below 0x8000 and pin source: top bit records edge polarity.
// - Input capture sets channel flag on valid result, buffer flag on data.
// - Frequency capture: rising event captures and restarts the counter.
// - Pulse-width capture: restart on rising, capture on falling, pin both edges.
// - Event delay option delays capture event by one clock for cascading.
// - Capture with buffer and channel flag both set is dropped unless the channel is read that cycle; error set either way.
// - Counter equal to channel value sets channel flag one timer clock later.
// - Compare buffer moves to channel only at the mode's update point.
// - Frequency waveform: channel A is top, output toggles on every A match.
// - Frequency output is clock over 2 times prescale times A plus one.
// - Single slope: count bottom to top, set on match, clear at top.
// - PWM resolution from 2 bits (period 0x0003) to 16 bits.
// - Dual slope: up then down; set at bottom, clear up-match, set down-match.
// - Enabled channel in waveform mode overrides pin value, optionally inverted.
// - Overflow, per-channel and error interrupts, each with an event.
// - Compare buffer write sets buffer flag; update clears it on copy.
// - Capture buffer and channel form a two-deep queue; move sets flag.
// - Update point is bottom or top depending on waveform mode.
`default_nettype none
module tcc_channels (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Prescaled timer tick
  input  wire logic        count_tick,
  // Register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Event routing network
  input  wire logic [7:0]  ev_in,
  input  wire logic [7:0]  ev_rise,
  input  wire logic [7:0]  ev_from_pin,
  output logic             ovf_event,
  output logic      [3:0]  cc_event,
  output logic             err_event,
  // Interrupt request levels
  output logic             ovf_irq,
  output logic      [3:0]  cc_irq,
  output logic             err_irq,
  // Port pins
  input  wire logic [3:0]  port_out_value,
  input  wire logic [3:0]  pin_invert_enable,
  output logic      [3:0]  pin_out
);
  logic [15:0] ctrl_reg;
  logic [15:0] period_value_reg;
  logic [15:0] count_value_reg;
  logic        dir_up_reg;
  logic        ovf_flag_reg;
  logic        err_flag_reg;
  logic [7:0]  ev_d_reg;
  logic [7:0]  rise_d_reg;
  logic [7:0]  pin_d_reg;
  logic [15:0] channel_compare_value [4];
  logic [15:0] channel_value_buffer  [4];
  logic [3:0]  buffer_valid_flag;
  logic [3:0]  cc_flag;
  logic [3:0]  match_d_reg;
  logic [3:0]  waveform_output;
  logic [3:0]  err_hit;
  logic [3:0]  restart_hit;

  logic [2:0]  wave_mode;
  logic [2:0]  event_action_select;
  logic [2:0]  event_source_select;
  logic [3:0]  channel_enable;
  logic        event_delay_option;
  logic [7:0]  ev_use;
  logic [7:0]  rise_use;
  logic [7:0]  pin_use;
  logic [15:0] top_value;
  logic        at_top;
  logic        at_bottom;
  logic        is_dual;
  logic        is_pwm;
  logic        capture_use;
  logic        update_now;
  logic        ovf_now;
  logic        restart_now;
  logic        wr_status;

  assign wave_mode           = ctrl_reg[tcc_pkg::CTRL_MODE_LSB +: 3];
  assign channel_enable      = ctrl_reg[tcc_pkg::CTRL_EN_LSB +: 4];
  assign event_delay_option  = ctrl_reg[tcc_pkg::CTRL_DLY_BIT];
  assign event_action_select = ctrl_reg[tcc_pkg::CTRL_ACT_LSB +: 3];
  assign event_source_select = ctrl_reg[tcc_pkg::CTRL_SEL_LSB +: 3];
  // Delayed copy lines the upper timer up with the lower one's overflow
  assign ev_use    = event_delay_option ? ev_d_reg : ev_in;
  assign rise_use  = event_delay_option ? rise_d_reg : ev_rise;
  // Pin qualifier travels with its event, or a delayed stamp takes a stale polarity
  assign pin_use   = event_delay_option ? pin_d_reg : ev_from_pin;
  assign is_dual   = wave_mode[2];
  assign is_pwm    = (wave_mode == tcc_pkg::TCC_WG_SS) || is_dual;
  // Frequency mode takes channel A as its top
  assign top_value = (wave_mode == tcc_pkg::TCC_WG_FRQ) ? channel_compare_value[0]
                                                        : period_value_reg;
  assign at_top    = (count_value_reg == top_value);
  assign at_bottom = (count_value_reg == 16'h0000);
  assign capture_use = (event_action_select == tcc_pkg::TCC_ACT_CAPT) ||
                       (event_action_select == tcc_pkg::TCC_ACT_FRQ)  ||
                       (event_action_select == tcc_pkg::TCC_ACT_PW);
  assign update_now  = count_tick && (is_pwm ? at_bottom : at_top);
  assign ovf_now     = count_tick && (
                       (wave_mode == tcc_pkg::TCC_WG_SS)     ? at_bottom :
                       (wave_mode == tcc_pkg::TCC_WG_DSTOP)  ? at_top :
                       (wave_mode == tcc_pkg::TCC_WG_DSBOTH) ? (at_top || at_bottom) :
                       (wave_mode == tcc_pkg::TCC_WG_DSBOT)  ? at_bottom : at_top);
  assign restart_now = |restart_hit;
  assign wr_status   = reg_wr && (reg_addr == tcc_pkg::ADDR_STATUS);

  // Control and period registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg         <= tcc_pkg::CTRL_RST;
      period_value_reg <= tcc_pkg::PERIOD_RST;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == tcc_pkg::ADDR_CTRL)
        ctrl_reg <= reg_wdata;
      else if (reg_addr == tcc_pkg::ADDR_PERIOD)
        period_value_reg <= reg_wdata;
    end
  end

  // One-clock event delay stage
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ev_d_reg   <= 8'h00;
      rise_d_reg <= 8'h00;
      pin_d_reg  <= 8'h00;
    end
    else if (clk_en)
    begin
      ev_d_reg   <= ev_in;
      rise_d_reg <= ev_rise;
      pin_d_reg  <= ev_from_pin;
    end
  end

  // Counter: bus write first, then capture restart, then counting
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_value_reg <= 16'h0000;
      dir_up_reg      <= 1'b1;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == tcc_pkg::ADDR_COUNT)
        count_value_reg <= reg_wdata;
      else if (restart_now)
        count_value_reg <= 16'h0000;
      else if (count_tick && is_dual)
      begin
        // Turn at both ends so top and bottom each last one tick
        if (dir_up_reg && at_top)
        begin
          dir_up_reg      <= 1'b0;
          count_value_reg <= count_value_reg - 16'h0001;
        end
        else if (!dir_up_reg && at_bottom)
        begin
          dir_up_reg      <= 1'b1;
          count_value_reg <= count_value_reg + 16'h0001;
        end
        else if (dir_up_reg)
          count_value_reg <= count_value_reg + 16'h0001;
        else
          count_value_reg <= count_value_reg - 16'h0001;
      end
      else if (count_tick)
      begin
        dir_up_reg      <= 1'b1;
        count_value_reg <= at_top ? 16'h0000 : count_value_reg + 16'h0001;
      end
    end
  end

  // Overflow and error flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ovf_now)
        ovf_flag_reg <= 1'b1;
      else if (wr_status && reg_wdata[tcc_pkg::ST_OVF_BIT])
        ovf_flag_reg <= 1'b0;
      if (|err_hit)
        err_flag_reg <= 1'b1;
      else if (wr_status && reg_wdata[tcc_pkg::ST_ERR_BIT])
        err_flag_reg <= 1'b0;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < tcc_pkg::NCH; ch++)
    begin : g_ch
      localparam logic [2:0] CH_OFS = 3'(ch);
      logic [2:0]  src;
      logic        ev_hit;
      logic        ev_r;
      logic        cap_now;
      logic        rd_cc;
      logic        wr_cc;
      logic        wr_buf;
      logic        match_now;
      logic [15:0] stamp;

      // Channel n follows the selected event channel n places on
      assign src     = event_source_select + CH_OFS;
      assign ev_hit  = ev_use[src] && channel_enable[ch] && capture_use;
      assign ev_r    = rise_use[src];
      assign cap_now = ev_hit && (
                       (event_action_select == tcc_pkg::TCC_ACT_CAPT) ||
                       (event_action_select == tcc_pkg::TCC_ACT_FRQ && ev_r) ||
                       (event_action_select == tcc_pkg::TCC_ACT_PW && !ev_r));
      assign restart_hit[ch] = ev_hit && ev_r &&
                       (event_action_select == tcc_pkg::TCC_ACT_FRQ ||
                        event_action_select == tcc_pkg::TCC_ACT_PW);
      assign err_hit[ch] = cap_now && buffer_valid_flag[ch] && cc_flag[ch];
      assign rd_cc  = reg_rd && (reg_addr == tcc_pkg::ADDR_CC0 + 5'(ch));
      assign wr_cc  = reg_wr && (reg_addr == tcc_pkg::ADDR_CC0 + 5'(ch));
      assign wr_buf = reg_wr && (reg_addr == tcc_pkg::ADDR_BUF0 + 5'(ch));
      assign match_now = (count_value_reg == channel_compare_value[ch]);
      // Edge polarity only fits while the count stays below half range
      assign stamp = (period_value_reg < tcc_pkg::POL_LIMIT && pin_use[src])
                     ? {ev_r, count_value_reg[14:0]} : count_value_reg;

      // Buffer, channel value and their flags
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          channel_value_buffer[ch]  <= tcc_pkg::CC_RST;
          channel_compare_value[ch] <= tcc_pkg::CC_RST;
          buffer_valid_flag[ch]     <= 1'b0;
          cc_flag[ch]               <= 1'b0;
        end
        else if (clk_en)
        begin
          if (capture_use)
          begin
            // Two-deep queue: full slot drops the newcomer
            if ((!cc_flag[ch] || rd_cc) && buffer_valid_flag[ch])
            begin
              channel_compare_value[ch] <= channel_value_buffer[ch];
              cc_flag[ch]               <= 1'b1;
              buffer_valid_flag[ch]     <= cap_now;
              if (cap_now)
                channel_value_buffer[ch] <= stamp;
            end
            else if (cap_now && !buffer_valid_flag[ch])
            begin
              channel_value_buffer[ch] <= stamp;
              buffer_valid_flag[ch]    <= 1'b1;
              if (rd_cc)
                cc_flag[ch] <= 1'b0;
            end
            else if (rd_cc || (wr_status && reg_wdata[tcc_pkg::ST_CC_LSB + ch]))
              cc_flag[ch] <= 1'b0;
            if (wr_cc)
              channel_compare_value[ch] <= reg_wdata;
          end
          else
          begin
            if (wr_cc)
              channel_compare_value[ch] <= reg_wdata;
            else if (update_now && buffer_valid_flag[ch])
              channel_compare_value[ch] <= channel_value_buffer[ch];
            if (wr_buf)
            begin
              channel_value_buffer[ch] <= reg_wdata;
              buffer_valid_flag[ch]    <= 1'b1;
            end
            else if (update_now)
              buffer_valid_flag[ch] <= 1'b0;
            if (count_tick && match_d_reg[ch])
              cc_flag[ch] <= 1'b1;
            else if (wr_status && reg_wdata[tcc_pkg::ST_CC_LSB + ch])
              cc_flag[ch] <= 1'b0;
          end
        end
      end

      // Match seen on one tick raises the flag on the next
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          match_d_reg[ch] <= 1'b0;
        else if (clk_en && count_tick)
          match_d_reg[ch] <= match_now && !capture_use;
      end

      // Waveform generator
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          waveform_output[ch] <= 1'b0;
        else if (clk_en && count_tick)
        begin
          case (wave_mode)
            tcc_pkg::TCC_WG_FRQ:
              if (ch == 0 && match_now)
                waveform_output[ch] <= !waveform_output[ch];
            tcc_pkg::TCC_WG_SS:
              if (at_top)
                waveform_output[ch] <= 1'b0;
              else if (match_now)
                waveform_output[ch] <= 1'b1;
            tcc_pkg::TCC_WG_DSTOP, tcc_pkg::TCC_WG_DSBOTH, tcc_pkg::TCC_WG_DSBOT:
              if (at_bottom)
                waveform_output[ch] <= 1'b1;
              else if (match_now)
                waveform_output[ch] <= !dir_up_reg;
            default:
              waveform_output[ch] <= waveform_output[ch];
          endcase
        end
      end

      // Pin override, registered so the pin is glitch free
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          pin_out[ch] <= 1'b0;
        else if (clk_en)
          pin_out[ch] <= (channel_enable[ch] && wave_mode != tcc_pkg::TCC_WG_NORMAL)
                         ? waveform_output[ch] ^ pin_invert_enable[ch]
                         : port_out_value[ch];
      end

      a_capture_stamp: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && cap_now && !buffer_valid_flag[ch] && cc_flag[ch] && !rd_cc
        |=> buffer_valid_flag[ch] && channel_value_buffer[ch] == $past(stamp))
        else $error("capture did not store the count");
      a_overflow_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && err_hit[ch] && !rd_cc
        |=> err_flag_reg && $stable(channel_value_buffer[ch]))
        else $error("capture overflow not rejected");
      a_compare_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && count_tick && match_now && !capture_use && !wr_cc
        ##1 (clk_en && count_tick && !capture_use) |=> cc_flag[ch])
        else $error("compare flag not set a tick after match");
      a_buffer_update: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !capture_use && update_now && buffer_valid_flag[ch] && !wr_cc && !wr_buf
        |=> channel_compare_value[ch] == $past(channel_value_buffer[ch])
            && !buffer_valid_flag[ch])
        else $error("compare buffer not moved at update");
      a_ss_clear_top: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && count_tick && wave_mode == tcc_pkg::TCC_WG_SS && at_top
        |=> !waveform_output[ch])
        else $error("single slope output not cleared at top");
      a_ds_bottom_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && count_tick && is_dual && at_bottom |=> waveform_output[ch])
        else $error("dual slope output not set at bottom");
      a_pin_override: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && channel_enable[ch] && wave_mode != tcc_pkg::TCC_WG_NORMAL
        |=> pin_out[ch] == ($past(waveform_output[ch]) ^ $past(pin_invert_enable[ch])))
        else $error("pin not overridden by waveform");
    end
  endgenerate

  // Events pulse one cycle; interrupt lines follow the sticky flags
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_event <= 1'b0;
      cc_event  <= 4'h0;
      err_event <= 1'b0;
      ovf_irq   <= 1'b0;
      cc_irq    <= 4'h0;
      err_irq   <= 1'b0;
    end
    else if (clk_en)
    begin
      ovf_event <= ovf_now;
      cc_event  <= cc_flag & ~cc_irq;
      err_event <= |err_hit;
      ovf_irq   <= ovf_flag_reg;
      cc_irq    <= cc_flag;
      err_irq   <= err_flag_reg;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (clk_en && reg_rd)
    begin
      if (reg_addr == tcc_pkg::ADDR_CTRL)
        reg_rdata <= ctrl_reg;
      else if (reg_addr == tcc_pkg::ADDR_PERIOD)
        reg_rdata <= period_value_reg;
      else if (reg_addr == tcc_pkg::ADDR_COUNT)
        reg_rdata <= count_value_reg;
      else if (reg_addr == tcc_pkg::ADDR_STATUS)
        reg_rdata <= {6'h00, buffer_valid_flag, err_flag_reg, cc_flag, ovf_flag_reg};
      else if (reg_addr >= tcc_pkg::ADDR_CC0 && reg_addr < tcc_pkg::ADDR_CC0 + 5'h04)
        reg_rdata <= channel_compare_value[2'(reg_addr - tcc_pkg::ADDR_CC0)];
      else if (reg_addr >= tcc_pkg::ADDR_BUF0 && reg_addr < tcc_pkg::ADDR_BUF0 + 5'h04)
        reg_rdata <= channel_value_buffer[2'(reg_addr - tcc_pkg::ADDR_BUF0)];
      else
        reg_rdata <= 16'h0000;
    end
  end

  a_restart_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && restart_now && !(reg_wr && reg_addr == tcc_pkg::ADDR_COUNT)
    |=> count_value_reg == 16'h0000)
    else $error("restart did not clear the counter");
  a_frq_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && count_tick && wave_mode == tcc_pkg::TCC_WG_FRQ
    && count_value_reg == channel_compare_value[0]
    |=> waveform_output[0] != $past(waveform_output[0]))
    else $error("frequency output did not toggle");
endmodule
`default_nettype wire

// ===== rtl/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
  // Geometry
  localparam int NCH = 4;
  localparam int NEV = 8;
  localparam int AW  = 5;
  localparam int DW  = 16;

  // Register indices on the plain port
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_PERIOD = 5'h01;
  localparam logic [4:0] ADDR_COUNT  = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_CC0    = 5'h08;
  localparam logic [4:0] ADDR_BUF0   = 5'h0C;

  // Control field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_EN_LSB    = 4;
  localparam int CTRL_DLY_BIT   = 8;
  localparam int CTRL_ACT_LSB   = 9;
  localparam int CTRL_SEL_LSB   = 12;

  // Status field positions (write one to clear, except the buffer-valid bits)
  localparam int ST_OVF_BIT = 0;
  localparam int ST_CC_LSB  = 1;
  localparam int ST_ERR_BIT = 5;
  localparam int ST_BV_LSB  = 6;

  // Reset values and capture polarity limit
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CC_RST     = 16'h0000;
  localparam logic [15:0] POL_LIMIT  = 16'h8000;

  // Waveform modes
  typedef enum logic [2:0] {
    TCC_WG_NORMAL = 3'b000,
    TCC_WG_FRQ    = 3'b001,
    TCC_WG_SS     = 3'b011,
    TCC_WG_DSTOP  = 3'b101,
    TCC_WG_DSBOTH = 3'b110,
    TCC_WG_DSBOT  = 3'b111
  } tcc_wg_t;

  // Event actions
  typedef enum logic [2:0] {
    TCC_ACT_OFF  = 3'b000,
    TCC_ACT_CAPT = 3'b001,
    TCC_ACT_FRQ  = 3'b101,
    TCC_ACT_PW   = 3'b110
  } tcc_act_t;
endpackage
`default_nettype wire

// ===== verification/tcc_channels_tb.sv
`default_nettype none
module tcc_channels_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;
  logic        arst_n;
  logic        clk_en;
  logic        count_tick;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [7:0]  ev_in;
  logic [7:0]  ev_rise;
  logic [7:0]  ev_from_pin;
  logic [3:0]  port_out_value;
  logic [3:0]  pin_invert_enable;
  logic [3:0]  pin_out;
  logic        ovf_event;
  logic [3:0]  cc_event;
  logic        err_event;
  logic        ovf_irq;
  logic [3:0]  cc_irq;
  logic        err_irq;
  logic        rd_pend;
  logic        prev;
  logic [15:0] exp_q[$];
  logic [15:0] v1;
  logic [15:0] v2;
  int          bad_count;
  int          samples_checked;
  int          highs;
  int          err_pulses = 0;
  int          cc_pulses = 0;

  // Clock source
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  tcc_channels i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .count_tick(count_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_in(ev_in), .ev_rise(ev_rise),
    .ev_from_pin(ev_from_pin), .ovf_event(ovf_event), .cc_event(cc_event),
    .err_event(err_event), .ovf_irq(ovf_irq), .cc_irq(cc_irq), .err_irq(err_irq),
    .port_out_value(port_out_value),
    .pin_invert_enable(pin_invert_enable), .pin_out(pin_out));

  tcc_ev_model i_ev (.ref_clk(ref_clk), .ev_in(ev_in), .ev_rise(ev_rise),
    .ev_from_pin(ev_from_pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; a read notes its expected data for the monitor
  task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= ~w;
    if (!w)
      exp_q.push_back(d);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // Read data arrive in the cycle after the strobe and hold until the next read
  always @(posedge ref_clk)
  begin
    if (rd_pend)
      chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  // Event pulses counted; each condition here fires exactly once
  always @(posedge ref_clk)
  begin
    if (err_event)
      err_pulses++;
    if (cc_event[1])
      cc_pulses++;
  end

  // Hang guard
  initial
  begin
    #2000000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    count_tick = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_pend = 1'b0;
    port_out_value = 4'h0;
    pin_invert_enable = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'hCCD86195));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    bus(tcc_pkg::ADDR_PERIOD, tcc_pkg::PERIOD_RST, 1'b0);
    bus(5'h04, 16'h0000, 1'b0);
    // Counter frozen so stamps are exact; only channel A enabled, source 2
    v1 = 16'($urandom()) & 16'h7FFF;
    v2 = 16'($urandom()) & 16'h7FFF;
    bus(tcc_pkg::ADDR_PERIOD, 16'h7FFF, 1'b1);
    bus(tcc_pkg::ADDR_CTRL, 16'h2210, 1'b1);
    bus(tcc_pkg::ADDR_COUNT, v1, 1'b1);
    i_ev.fire(2, 1'b1, 1'b1, 0);
    i_ev.fire(3, 1'b1, 1'b1, 2);
    bus(tcc_pkg::ADDR_COUNT, v2, 1'b1);
    i_ev.fire(2, 1'b0, 1'b1, 0);
    i_ev.fire(2, 1'b1, 1'b1, 3);
    bus(tcc_pkg::ADDR_STATUS, 16'h0062, 1'b0);
    @(negedge ref_clk);
    chk({10'h000, cc_irq, err_irq, ovf_irq}, 16'h0006);
    bus(tcc_pkg::ADDR_CC0, v1 | 16'h8000, 1'b0);
    bus(tcc_pkg::ADDR_CC0, v2, 1'b0);
    bus(tcc_pkg::ADDR_CC0 + 5'h01, 16'h0000, 1'b0);
    bus(tcc_pkg::ADDR_STATUS, 16'hFFFF, 1'b1);
    // Delayed capture on a running counter stamps one count later
    bus(tcc_pkg::ADDR_CTRL, 16'h2310, 1'b1);
    count_tick <= 1'b1;
    bus(tcc_pkg::ADDR_COUNT, v1 & 16'h0FFF, 1'b1);
    i_ev.fire(2, 1'b1, 1'b0, 0);
    count_tick <= 1'b0;
    repeat (2) @(posedge ref_clk);
    bus(tcc_pkg::ADDR_CC0, (v1 & 16'h0FFF) + 16'h0002, 1'b0);
    // Frequency capture: stamp old count, restart to zero
    bus(tcc_pkg::ADDR_CTRL, 16'h2A10, 1'b1);
    bus(tcc_pkg::ADDR_COUNT, v1, 1'b1);
    i_ev.fire(2, 1'b1, 1'b0, 1);
    bus(tcc_pkg::ADDR_COUNT, 16'h0000, 1'b0);
    bus(tcc_pkg::ADDR_CC0, v1, 1'b0);
    // Pulse width: rising restarts only, falling stamps
    bus(tcc_pkg::ADDR_CTRL, 16'h2C10, 1'b1);
    bus(tcc_pkg::ADDR_COUNT, v2, 1'b1);
    i_ev.fire(2, 1'b1, 1'b1, 0);
    bus(tcc_pkg::ADDR_COUNT, 16'h0000, 1'b0);
    bus(tcc_pkg::ADDR_COUNT, v1, 1'b1);
    i_ev.fire(2, 1'b0, 1'b1, 0);
    bus(tcc_pkg::ADDR_CC0, v1, 1'b0);
    // Frequency waveform at its fastest: channel A zero, tick every cycle
    bus(tcc_pkg::ADDR_CC0, 16'h0000, 1'b1);
    bus(tcc_pkg::ADDR_COUNT, 16'h0000, 1'b1);
    bus(tcc_pkg::ADDR_CTRL, 16'h0011, 1'b1);
    count_tick <= 1'b1;
    pin_invert_enable <= 4'($urandom());
    port_out_value <= 4'($urandom());
    repeat (4) @(negedge ref_clk);
    prev = pin_out[0];
    repeat (6)
    begin
      @(negedge ref_clk);
      chk({15'h0000, pin_out[0]}, {15'h0000, ~prev});
      chk({11'h000, ovf_event, cc_irq}, 16'h001F);
      prev = pin_out[0];
    end
    // Buffered compare value moves in at the update point, top in this mode
    bus(tcc_pkg::ADDR_BUF0 + 5'h01, v2, 1'b1);
    bus(tcc_pkg::ADDR_CC0 + 5'h01, v2, 1'b0);
    // Smallest PWM period on channel B: single slope, then dual slope
    bus(tcc_pkg::ADDR_PERIOD, 16'h0003, 1'b1);
    bus(tcc_pkg::ADDR_CC0 + 5'h01, 16'h0002, 1'b1);
    bus(tcc_pkg::ADDR_CTRL, 16'h0023, 1'b1);
    repeat (8) @(negedge ref_clk);
    highs = 0;
    repeat (8)
    begin
      @(negedge ref_clk);
      highs += int'(pin_out[1]);
    end
    chk(16'(highs), pin_invert_enable[1] ? 16'h0006 : 16'h0002);
    bus(tcc_pkg::ADDR_CTRL, 16'h0025, 1'b1);
    repeat (12) @(negedge ref_clk);
    highs = 0;
    repeat (6)
    begin
      @(negedge ref_clk);
      highs += int'(pin_out[1]);
    end
    chk(16'(highs), pin_invert_enable[1] ? 16'h0002 : 16'h0004);
    // Normal mode leaves the port value in charge
    bus(tcc_pkg::ADDR_CTRL, 16'h0010, 1'b1);
    count_tick <= 1'($urandom());
    repeat (3) @(negedge ref_clk);
    chk({12'h000, pin_out}, {12'h000, port_out_value});
    chk(16'(err_pulses), 16'h0001);
    chk(16'(cc_pulses), 16'h0001);
    repeat (3) @(posedge ref_clk);
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verification/tcc_ev_model.sv
`default_nettype none
// Event network and pin edge detector seen from the timer channels
module tcc_ev_model (
  // Clock
  input  wire logic       ref_clk,
  // Event channels
  output logic      [7:0] ev_in,
  output logic      [7:0] ev_rise,
  output logic      [7:0] ev_from_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Qualifiers hold junk between events so a stale value never looks valid
  initial
  begin
    ev_in       = 8'h00;
    ev_rise     = 8'h5A;
    ev_from_pin = 8'hA5;
  end

  // One-cycle pulse per detected pin edge, with optional slow start
  task automatic fire(input int idx, input logic rise, input logic pin, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    ev_in[idx]       <= 1'b1;
    ev_rise[idx]     <= rise;
    ev_from_pin[idx] <= pin;
    @(posedge ref_clk);
    ev_in       <= 8'h00;
    ev_rise     <= ~ev_rise;
    ev_from_pin <= ~ev_from_pin;
  endtask
endmodule
`default_nettype wire
